// File: fltrc_fault_ctrl.sv
module fltrc_fault_ctrl import fltrc_pkg::*; #(
    parameter int unsigned CONT_CYC = CONT_UNIT_CYC,
    parameter int unsigned SPACE_CYC = SPACE_UNIT_CYC
) (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic [7:0] cmd_code,
    input wire logic cmd_wr,
    input wire logic cmd_rd,
    input wire logic [15:0] cmd_wdata,
    output logic [15:0] cmd_rdata,
    output logic cmd_rvalid,
    input wire logic [15:0] iout_meas,
    input wire logic [15:0] temp_meas,
    input wire logic enable_cmd,
    output logic out_enable,
    input wire logic alert_line_n_i,
    output logic alert_line_n_o,
    output logic alert_line_n_oe
);

    fltrc_regs_t q, d;
    logic oc_fault, uc_fault, ot_fault, other_fault;
    logic [1:0] resp;
    logic [2:0] retry, delay;
    logic cont_start, space_start, space_abort;
    logic cont_done, space_done;
    logic [2:0] sts_set, sts_clr;

    // codes are compared raw; the monitor must deliver the same exponent
    assign oc_fault = iout_meas > q.oc_thr;
    assign uc_fault = iout_meas < q.uc_thr;
    assign ot_fault = temp_meas > q.ot_thr;
    assign other_fault = oc_fault | uc_fault;
    assign resp = q.ot_act[RESP_HI:RESP_LO];
    assign retry = q.ot_act[RETRY_HI:RETRY_LO];
    assign delay = q.ot_act[DELAY_HI:DELAY_LO];

    fltrc_delay_timer #(
        .UNIT_CYC(CONT_CYC)
    ) u_cont_tmr (
        .mclk(mclk),
        .reset_n(reset_n),
        .start(cont_start),
        .abort(1'b0),
        .units(delay),
        .done(cont_done),
        .busy()
    );

    fltrc_delay_timer #(
        .UNIT_CYC(SPACE_CYC)
    ) u_space_tmr (
        .mclk(mclk),
        .reset_n(reset_n),
        .start(space_start),
        .abort(space_abort),
        .units(delay),
        .done(space_done),
        .busy()
    );

    always_comb begin
        d = q;
        cont_start = 1'b0;
        space_start = 1'b0;
        space_abort = 1'b0;
        d.rvalid = cmd_rd;
        sts_set = {ot_fault, uc_fault, oc_fault};
        sts_clr = '0;

        if (cmd_wr) begin
            case (cmd_code)
                CMD_OC_THR: d.oc_thr = cmd_wdata;
                CMD_UC_THR: d.uc_thr = cmd_wdata;
                CMD_OT_THR: d.ot_thr = cmd_wdata;
                CMD_OT_ACT: d.ot_act = cmd_wdata[7:0];
                CMD_STATUS: sts_clr = cmd_wdata[2:0];
                default: ;
            endcase
        end
        // a fault in the clearing cycle keeps its bit
        d.sts = (q.sts & ~sts_clr) | sts_set;

        if (cmd_rd) begin
            case (cmd_code)
                CMD_OC_THR: d.rdata = q.oc_thr;
                CMD_UC_THR: d.rdata = q.uc_thr;
                CMD_OT_THR: d.rdata = q.ot_thr;
                CMD_OT_ACT: d.rdata = {8'h00, q.ot_act};
                CMD_STATUS: d.rdata = {13'h0000, q.sts};
                default: d.rdata = 16'h0000;
            endcase
        end

        if (!enable_cmd) begin
            // a disable command ends any restart sequence
            d.st = ST_RUN;
            d.tries = 3'h0;
            d.run_en = 1'b1;
            space_abort = 1'b1;
        end else begin
            case (q.st)
                ST_RUN: begin
                    d.run_en = 1'b1;
                    if (ot_fault) begin
                        case (resp)
                            RESP_IGNORE: d.st = ST_RUN;
                            RESP_CONT: begin
                                cont_start = 1'b1;
                                d.st = ST_CONT;
                            end
                            RESP_DIS_RETRY: begin
                                d.run_en = 1'b0;
                                d.tries = 3'h0;
                                if (retry == RETRY_NONE) begin
                                    d.st = ST_LOCK;
                                end else begin
                                    space_start = 1'b1;
                                    d.st = ST_WAIT;
                                end
                            end
                            RESP_DIS_CLEAR: begin
                                d.run_en = 1'b0;
                                d.st = ST_HOLD;
                            end
                            default: d.st = ST_RUN;
                        endcase
                    end
                end
                ST_CONT: begin
                    d.run_en = 1'b1;
                    if (cont_done) begin
                        if (!ot_fault) begin
                            d.st = ST_RUN;
                        end else if (retry == RETRY_NONE) begin
                            d.run_en = 1'b0;
                            d.st = ST_LOCK;
                        end else begin
                            d.run_en = 1'b0;
                            d.tries = 3'h0;
                            space_start = 1'b1;
                            d.st = ST_WAIT;
                        end
                    end
                end
                ST_WAIT: begin
                    d.run_en = 1'b0;
                    if (other_fault) begin
                        space_abort = 1'b1;
                        d.st = ST_LOCK;
                    end else if (space_done) begin
                        // spacing runs from one attempt start to the next
                        space_start = 1'b1;
                        d.run_en = 1'b1;
                        if (retry != RETRY_FOREVER) begin
                            d.tries = q.tries + 3'h1;
                        end
                        d.st = ST_TRY;
                    end
                end
                ST_TRY: begin
                    d.run_en = 1'b1;
                    if (other_fault) begin
                        space_abort = 1'b1;
                        d.run_en = 1'b0;
                        d.st = ST_LOCK;
                    end else if (ot_fault) begin
                        d.run_en = 1'b0;
                        if (retry != RETRY_FOREVER && q.tries >= retry) begin
                            space_abort = 1'b1;
                            d.st = ST_LOCK;
                        end else begin
                            // a fault on the spacing edge would leave the timer idle in wait
                            space_start = space_done;
                            d.st = ST_WAIT;
                        end
                    end else if (space_done) begin
                        d.tries = 3'h0;
                        d.st = ST_RUN;
                    end
                end
                ST_LOCK: begin
                    d.run_en = 1'b0;
                    // released when the host has cleared the fault bit, or by a disable command
                    if (!q.sts[STS_OT]) begin
                        d.tries = 3'h0;
                        d.run_en = 1'b1;
                        d.st = ST_RUN;
                    end
                end
                ST_HOLD: begin
                    d.run_en = 1'b0;
                    if (!ot_fault) begin
                        d.run_en = 1'b1;
                        d.st = ST_RUN;
                    end
                end
                default: begin
                    d.st = ST_RUN;
                    d.run_en = 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            q.st <= ST_RUN;
            q.oc_thr <= RST_OC_THR;
            q.uc_thr <= RST_UC_THR;
            q.ot_thr <= RST_OT_THR;
            q.ot_act <= RST_OT_ACT;
            q.sts <= RST_STATUS;
            q.tries <= 3'h0;
            q.run_en <= 1'b1;
            q.rdata <= 16'h0000;
            q.rvalid <= 1'b0;
        end else begin
            q <= d;
        end
    end

    // other faults force the output off while they last
    assign out_enable = q.run_en & enable_cmd & ~other_fault;
    assign cmd_rdata = q.rdata;
    assign cmd_rvalid = q.rvalid;
    assign alert_line_n_o = 1'b0;
    assign alert_line_n_oe = |q.sts;

    alert_on_fault_a: assert property (@(posedge mclk) disable iff (!reset_n)
        ot_fault |=> alert_line_n_oe && q.sts[STS_OT]) else $error("alert missing");
    ignore_keeps_run_a: assert property (@(posedge mclk) disable iff (!reset_n)
        q.st == ST_RUN && enable_cmd && ot_fault && resp == RESP_IGNORE
        |=> q.st == ST_RUN && q.run_en) else $error("ignored fault stopped output");
    no_retry_lock_a: assert property (@(posedge mclk) disable iff (!reset_n)
        q.st == ST_RUN && enable_cmd && ot_fault && resp == RESP_DIS_RETRY
        && retry == RETRY_NONE |=> q.st == ST_LOCK && !out_enable) else $error("no lock");
    disable_now_a: assert property (@(posedge mclk) disable iff (!reset_n)
        q.st == ST_RUN && enable_cmd && ot_fault && resp == RESP_DIS_RETRY
        |=> !out_enable) else $error("output not disabled");
    hold_release_a: assert property (@(posedge mclk) disable iff (!reset_n)
        q.st == ST_HOLD && enable_cmd && !ot_fault |=> q.st == ST_RUN)
        else $error("hold not released");
    last_try_fail_a: assert property (@(posedge mclk) disable iff (!reset_n)
        q.st == ST_TRY && enable_cmd && ot_fault && !other_fault
        && retry != RETRY_FOREVER && q.tries >= retry |=> q.st == ST_LOCK)
        else $error("retries not exhausted");
    forever_retry_a: assert property (@(posedge mclk) disable iff (!reset_n)
        q.st == ST_TRY && enable_cmd && ot_fault && !other_fault && retry == RETRY_FOREVER
        |=> q.st == ST_WAIT ##0 !out_enable) else $error("endless retry stopped");
    cont_running_a: assert property (@(posedge mclk) disable iff (!reset_n)
        q.st == ST_CONT && enable_cmd && !other_fault |-> out_enable)
        else $error("output dropped during delay");
    lock_clear_a: assert property (@(posedge mclk) disable iff (!reset_n)
        q.st == ST_LOCK && enable_cmd && !q.sts[STS_OT] |=> q.tries == 3'h0 && q.st == ST_RUN)
        else $error("attempt counter kept");

    // entry into the delay and hold paths, and how the delay ends
    cont_enter_a: assert property (@(posedge mclk) disable iff (!reset_n)
        q.st == ST_RUN && enable_cmd && ot_fault && resp == RESP_CONT
        |=> q.st == ST_CONT && q.run_en) else $error("delay not started");
    hold_enter_a: assert property (@(posedge mclk) disable iff (!reset_n)
        q.st == ST_RUN && enable_cmd && ot_fault && resp == RESP_DIS_CLEAR
        |=> q.st == ST_HOLD && !out_enable) else $error("output not held off");
    cont_pass_a: assert property (@(posedge mclk) disable iff (!reset_n)
        q.st == ST_CONT && enable_cmd && cont_done && !ot_fault |=> q.st == ST_RUN)
        else $error("cleared fault not resumed");
    cont_expire_a: assert property (@(posedge mclk) disable iff (!reset_n)
        q.st == ST_CONT && enable_cmd && cont_done && ot_fault && retry != RETRY_NONE
        |=> q.st == ST_WAIT && !out_enable) else $error("delay expiry not acted on");
    cont_lock_a: assert property (@(posedge mclk) disable iff (!reset_n)
        q.st == ST_CONT && enable_cmd && cont_done && ot_fault && retry == RETRY_NONE
        |=> q.st == ST_LOCK) else $error("delay expiry not locked");

    // restart sequence
    try_start_a: assert property (@(posedge mclk) disable iff (!reset_n)
        q.st == ST_WAIT && enable_cmd && space_done && !other_fault
        |=> q.st == ST_TRY && q.run_en) else $error("attempt not started");
    wait_off_a: assert property (@(posedge mclk) disable iff (!reset_n)
        q.st == ST_WAIT |-> !out_enable) else $error("output on between attempts");
    try_fail_a: assert property (@(posedge mclk) disable iff (!reset_n)
        q.st == ST_TRY && enable_cmd && ot_fault |=> !out_enable)
        else $error("failed attempt kept output");
    try_pass_a: assert property (@(posedge mclk) disable iff (!reset_n)
        q.st == ST_TRY && enable_cmd && space_done && !ot_fault && !other_fault
        |=> q.st == ST_RUN && q.tries == 3'h0) else $error("surviving attempt not kept");
    lock_stays_a: assert property (@(posedge mclk) disable iff (!reset_n)
        q.st == ST_LOCK && enable_cmd && q.sts[STS_OT] |=> q.st == ST_LOCK)
        else $error("lock left before clear");
    other_lock_a: assert property (@(posedge mclk) disable iff (!reset_n)
        (q.st == ST_WAIT || q.st == ST_TRY) && enable_cmd && other_fault |=> q.st == ST_LOCK)
        else $error("other fault did not end retries");
    disable_cmd_a: assert property (@(posedge mclk) disable iff (!reset_n)
        !enable_cmd |=> q.st == ST_RUN && q.tries == 3'h0 && q.run_en)
        else $error("disable did not end retries");
    status_clear_a: assert property (@(posedge mclk) disable iff (!reset_n)
        cmd_wr && cmd_code == CMD_STATUS && cmd_wdata[STS_OT] && !ot_fault
        |=> !q.sts[STS_OT]) else $error("fault bit not cleared");

    // register port: writes land at the edge, reads answer one edge later
    oc_thr_wr_a: assert property (@(posedge mclk) disable iff (!reset_n)
        cmd_wr && cmd_code == CMD_OC_THR |=> q.oc_thr == $past(cmd_wdata))
        else $error("over-current threshold not written");
    uc_thr_wr_a: assert property (@(posedge mclk) disable iff (!reset_n)
        cmd_wr && cmd_code == CMD_UC_THR |=> q.uc_thr == $past(cmd_wdata))
        else $error("under-current threshold not written");
    ot_thr_wr_a: assert property (@(posedge mclk) disable iff (!reset_n)
        cmd_wr && cmd_code == CMD_OT_THR |=> q.ot_thr == $past(cmd_wdata))
        else $error("temperature threshold not written");
    act_wr_a: assert property (@(posedge mclk) disable iff (!reset_n)
        cmd_wr && cmd_code == CMD_OT_ACT |=> q.ot_act == $past(cmd_wdata[7:0]))
        else $error("response byte not written");
    read_answer_a: assert property (@(posedge mclk) disable iff (!reset_n)
        cmd_rd |=> cmd_rvalid) else $error("read not answered");

    lock_seen_c: cover property (@(posedge mclk) disable iff (!reset_n)
        q.st == ST_TRY ##1 q.st == ST_LOCK);
    try_success_c: cover property (@(posedge mclk) disable iff (!reset_n)
        q.st == ST_TRY && space_done && !ot_fault);
    hold_seen_c: cover property (@(posedge mclk) disable iff (!reset_n)
        q.st == ST_HOLD ##1 q.st == ST_RUN);
    alert_seen_c: cover property (@(posedge mclk) disable iff (!reset_n)
        !alert_line_n_i && alert_line_n_oe);
    cont_expire_c: cover property (@(posedge mclk) disable iff (!reset_n)
        q.st == ST_CONT ##1 q.st == ST_WAIT);

endmodule // fltrc_fault_ctrl

// File: fltrc_pkg.sv
package fltrc_pkg;

    // command codes of the threshold, response and status registers
    localparam logic [7:0] CMD_OC_THR = 8'h46;
    localparam logic [7:0] CMD_UC_THR = 8'h4b;
    localparam logic [7:0] CMD_OT_THR = 8'h4f;
    localparam logic [7:0] CMD_OT_ACT = 8'h50;
    localparam logic [7:0] CMD_STATUS = 8'he0;

    // fields of the response byte
    localparam int RESP_HI = 7;
    localparam int RESP_LO = 6;
    localparam int RETRY_HI = 5;
    localparam int RETRY_LO = 3;
    localparam int DELAY_HI = 2;
    localparam int DELAY_LO = 0;

    // status bit positions
    localparam int STS_OC = 0;
    localparam int STS_UC = 1;
    localparam int STS_OT = 2;

    // values after reset
    localparam logic [15:0] RST_OC_THR = 16'hffff;
    localparam logic [15:0] RST_UC_THR = 16'h0000;
    localparam logic [15:0] RST_OT_THR = 16'hffff;
    localparam logic [7:0] RST_OT_ACT = 8'h80;
    localparam logic [2:0] RST_STATUS = 3'h0;

    localparam logic [1:0] RESP_IGNORE = 2'h0;
    localparam logic [1:0] RESP_CONT = 2'h1;
    localparam logic [1:0] RESP_DIS_RETRY = 2'h2;
    localparam logic [1:0] RESP_DIS_CLEAR = 2'h3;
    localparam logic [2:0] RETRY_NONE = 3'h0;
    localparam logic [2:0] RETRY_FOREVER = 3'h7;

    // time units and their cycle counts at the core clock
    localparam real CLK_PERIOD_NS = 5.0;
    localparam real CONT_UNIT_MS = 10.0;
    localparam real SPACE_UNIT_MS = 8.2;
    localparam int unsigned CONT_UNIT_CYC = $rtoi(CONT_UNIT_MS * 1.0e6 / CLK_PERIOD_NS + 0.5);
    localparam int unsigned SPACE_UNIT_CYC = $rtoi(SPACE_UNIT_MS * 1.0e6 / CLK_PERIOD_NS + 0.5);
    localparam int TMR_W = 21;

    typedef enum logic [2:0] {
        ST_RUN = 3'h0,
        ST_CONT = 3'h1,
        ST_WAIT = 3'h2,
        ST_TRY = 3'h3,
        ST_LOCK = 3'h4,
        ST_HOLD = 3'h5
    } fltrc_state_t;

    typedef struct packed {
        fltrc_state_t st;
        logic [15:0] oc_thr;
        logic [15:0] uc_thr;
        logic [15:0] ot_thr;
        logic [7:0] ot_act;
        logic [2:0] sts;
        logic [2:0] tries;
        logic run_en;
        logic [15:0] rdata;
        logic rvalid;
    } fltrc_regs_t;

    typedef struct packed {
        logic busy;
        logic done;
        logic [TMR_W-1:0] tick;
        logic [2:0] left;
    } fltrc_tmr_t;

endpackage : fltrc_pkg

// File: fltrc_delay_timer.sv
module fltrc_delay_timer import fltrc_pkg::*; #(
    parameter int unsigned UNIT_CYC = 1
) (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic start,
    input wire logic abort,
    input wire logic [2:0] units,
    output logic done,
    output logic busy
);

    fltrc_tmr_t q, d;

    always_comb begin
        d = q;
        d.done = 1'b0;
        if (abort) begin
            d.busy = 1'b0;
        end else if (start) begin
            // zero units expires on the very next edge
            d.busy = (units != 3'h0);
            d.done = (units == 3'h0);
            d.tick = '0;
            d.left = units;
        end else if (q.busy) begin
            if (q.tick == TMR_W'(UNIT_CYC - 1)) begin
                d.tick = '0;
                d.left = q.left - 3'h1;
                if (q.left == 3'h1) begin
                    d.busy = 1'b0;
                    d.done = 1'b1;
                end
            end else begin
                d.tick = q.tick + TMR_W'(1);
            end
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign done = q.done;
    assign busy = q.busy;

    zero_units_a: assert property (@(posedge mclk) disable iff (!reset_n)
        start && !abort && units == 3'h0 |=> done) else $error("zero delay did not expire");
    unit_length_a: assert property (@(posedge mclk) disable iff (!reset_n)
        start && !abort && units != 3'h0 |=> !done && busy) else $error("delay ended early");

endmodule // fltrc_delay_timer

// File: fltrc_host_model.sv
module fltrc_host_model (
    input wire logic mclk,
    output logic [7:0] cmd_code,
    output logic cmd_wr,
    output logic cmd_rd,
    output logic [15:0] cmd_wdata,
    input wire logic [15:0] cmd_rdata,
    input wire logic cmd_rvalid
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        cmd_code = 8'h00;
        cmd_wr = 1'b0;
        cmd_rd = 1'b0;
        cmd_wdata = 16'h0000;
    end

    task automatic wr(input logic [7:0] c, input logic [15:0] d);
        @(posedge mclk);
        cmd_code <= c;
        cmd_wdata <= d;
        cmd_wr <= 1'b1;
        @(posedge mclk);
        cmd_wr <= 1'b0;
        // released lines must not keep showing the old value
        cmd_code <= ~c;
        cmd_wdata <= ~d;
    endtask

    // response bytes go as byte transfers, upper half zero
    task automatic wr_byte(input logic [7:0] c, input logic [7:0] b);
        wr(c, {8'h00, b});
    endtask

    task automatic rd(input logic [7:0] c, output logic [15:0] d, output logic ok);
        ok = 1'b0;
        d = 16'h0000;
        @(posedge mclk);
        cmd_code <= c;
        cmd_rd <= 1'b1;
        @(posedge mclk);
        cmd_rd <= 1'b0;
        cmd_code <= ~c;
        for (int i = 0; i < 4 && !ok; i++) begin
            @(negedge mclk);
            if (cmd_rvalid === 1'b1) begin
                ok = 1'b1;
                d = cmd_rdata;
            end
        end
    endtask
endmodule // fltrc_host_model

// File: test_fault_limit_retry_control.sv
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin errors++; \
    $display("[ERR] %s exp %0h got %0h", nm, e, g); end end

module test_fault_limit_retry_control import fltrc_pkg::*; ();
    timeunit 1ns;
    timeprecision 1ps;
    localparam int unsigned CONT = 10;
    localparam int unsigned SPACE = 8;
    localparam logic [15:0] HOT = 16'h0200;
    localparam logic [15:0] COOL = 16'h0080;
    logic mclk, reset_n, cmd_wr, cmd_rd, cmd_rvalid, enable_cmd, out_enable;
    logic alert_line_n_o, alert_line_n_oe;
    logic [7:0] cmd_code;
    logic [15:0] cmd_wdata, cmd_rdata, iout_meas, temp_meas;
    int errors = 0;
    int n_checks = 0;
    int cyc = 0;
    int rises = 0;
    int last_rise = 0;
    int gap = 0;
    logic prev_en = 1'b0;
    // pull-up on the shared alert line
    wire alert_line_n = alert_line_n_oe ? alert_line_n_o : 1'b1;

    fltrc_fault_ctrl #(.CONT_CYC(CONT), .SPACE_CYC(SPACE)) u_fltrc_fault_ctrl (
        .mclk(mclk), .reset_n(reset_n), .cmd_code(cmd_code), .cmd_wr(cmd_wr),
        .cmd_rd(cmd_rd), .cmd_wdata(cmd_wdata), .cmd_rdata(cmd_rdata),
        .cmd_rvalid(cmd_rvalid), .iout_meas(iout_meas), .temp_meas(temp_meas),
        .enable_cmd(enable_cmd), .out_enable(out_enable), .alert_line_n_i(alert_line_n),
        .alert_line_n_o(alert_line_n_o), .alert_line_n_oe(alert_line_n_oe));

    fltrc_host_model u_fltrc_host_model (
        .mclk(mclk), .cmd_code(cmd_code), .cmd_wr(cmd_wr), .cmd_rd(cmd_rd),
        .cmd_wdata(cmd_wdata), .cmd_rdata(cmd_rdata), .cmd_rvalid(cmd_rvalid));

    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end

    // restart attempts seen as rising output enables, sampled mid-cycle
    always @(negedge mclk) begin
        cyc <= cyc + 1;
        prev_en <= out_enable;
        if (out_enable === 1'b1 && prev_en === 1'b0) begin
            rises <= rises + 1;
            gap <= cyc - last_rise;
            last_rise <= cyc;
        end
    end

    task automatic test_done();
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
    endtask

    // outputs are looked at mid-cycle, where they have settled
    task automatic look(input int n);
        repeat (n) @(posedge mclk);
        @(negedge mclk);
    endtask

    task automatic rchk(input logic [7:0] c, input logic [15:0] e, input string nm);
        logic [15:0] d;
        logic ok;
        u_fltrc_host_model.rd(c, d, ok);
        `CHK("read handshake", 1'b1, ok)
        if (ok !== 1'b1) test_done();
        `CHK(nm, e, d)
    endtask

    task automatic heat(input logic on);
        @(posedge mclk);
        temp_meas <= on ? HOT : COOL;
    endtask

    // fault gone, output command cycled, status cleared
    task automatic recover();
        @(posedge mclk);
        temp_meas <= COOL;
        iout_meas <= 16'h0400;
        enable_cmd <= 1'b0;
        tick(2);
        enable_cmd <= 1'b1;
        u_fltrc_host_model.wr(CMD_STATUS, 16'h0007);
        tick(3);
    endtask

    initial begin
        reset_n = 1'b0;
        enable_cmd = 1'b1;
        iout_meas = 16'h0400;
        temp_meas = COOL;
        tick(5);
        reset_n <= 1'b1;
        rchk(CMD_OC_THR, 16'hffff, "oc reset");
        rchk(CMD_UC_THR, 16'h0000, "uc reset");
        rchk(CMD_OT_THR, 16'hffff, "ot reset");
        rchk(CMD_OT_ACT, 16'h0080, "action reset");
        rchk(8'h99, 16'h0000, "unmapped");
        u_fltrc_host_model.wr(CMD_OC_THR, 16'h0800);
        u_fltrc_host_model.wr(CMD_OT_THR, 16'h0100);
        rchk(CMD_OC_THR, 16'h0800, "oc rw");
        rchk(CMD_OT_THR, 16'h0100, "ot rw");
        $display("test registers finished");

        u_fltrc_host_model.wr_byte(CMD_OT_ACT, 8'h00);
        rchk(CMD_OT_ACT, 16'h0000, "action rw");
        heat(1'b1);
        look(30);
        `CHK("ignore keeps output", 1'b1, out_enable)
        `CHK("alert low", 1'b0, alert_line_n)
        u_fltrc_host_model.wr(CMD_STATUS, 16'h0004);
        rchk(CMD_STATUS, 16'h0004, "status held while hot");
        recover();
        `CHK("alert released", 1'b1, alert_line_n)
        $display("test ignore finished");

        u_fltrc_host_model.wr_byte(CMD_OT_ACT, 8'h52);
        heat(1'b1);
        look(21);
        `CHK("running in delay", 1'b1, out_enable)
        look(1);
        `CHK("off after delay", 1'b0, out_enable)
        rchk(CMD_STATUS, 16'h0004, "ot status");
        recover();
        $display("test continue finished");

        for (int n = 0; n < 8; n++) begin
            u_fltrc_host_model.wr_byte(CMD_OT_ACT, {2'b10, n[2:0], 3'h1});
            @(posedge mclk);
            rises = 0;
            temp_meas <= HOT;
            look(3);
            `CHK("off at once", 1'b0, out_enable)
            look(150);
            if (n == 7) begin
                `CHK("unlimited tries", 1'b1, rises > 6)
            end else begin
                `CHK("tries", n, rises)
            end
            heat(1'b0);
            look(20);
            `CHK("locked until clear", n == 7, out_enable)
            u_fltrc_host_model.wr(CMD_STATUS, 16'h0004);
            look(3);
            `CHK("on after clear", 1'b1, out_enable)
            recover();
        end
        $display("test retry counts finished");

        u_fltrc_host_model.wr_byte(CMD_OT_ACT, 8'hbb);
        heat(1'b1);
        tick(100);
        `CHK("spacing", 1'b1, gap >= 3 * SPACE && gap <= 3 * SPACE + 2)
        recover();
        $display("test spacing finished");

        u_fltrc_host_model.wr_byte(CMD_OT_ACT, 8'hc0);
        heat(1'b1);
        look(3);
        `CHK("off while hot", 1'b0, out_enable)
        heat(1'b0);
        look(3);
        `CHK("back on", 1'b1, out_enable)
        recover();
        $display("test disable until clear finished");

        @(posedge mclk);
        iout_meas <= 16'h0900;
        look(2);
        `CHK("oc off", 1'b0, out_enable)
        @(posedge mclk);
        iout_meas <= 16'h0400;
        u_fltrc_host_model.wr(CMD_UC_THR, 16'h0200);
        rchk(CMD_UC_THR, 16'h0200, "uc rw");
        @(posedge mclk);
        iout_meas <= 16'h0100;
        look(2);
        `CHK("uc off", 1'b0, out_enable)
        rchk(CMD_STATUS, 16'h0003, "oc uc status");
        `CHK("alert on current", 1'b0, alert_line_n)
        recover();
        `CHK("alert clear", 1'b1, alert_line_n)
        $display("test current limits finished");
        test_done();
    end

    initial begin
        repeat (60000) @(posedge mclk);
        errors++;
        test_done();
    end
endmodule // test_fault_limit_retry_control
